/* hw/eir_router.sv */
`timescale 1ns/100ps
`default_nettype none
module eir_router
  import eir_pkg::*;
(
  // Clock and reset
  input  wire logic                              core_clk,
  input  wire logic                              rst,
  // Board request lines, asynchronous, active low
  input  wire logic                              nmi_req_n,
  input  wire logic [eir_pkg::EIR_ROUTABLE_LINES-1:0]  ext_irq_routable_n,
  input  wire logic [eir_pkg::EIR_CORE_ONLY_LINES-1:0] ext_irq_core_only_n,
  // Per-line route setting, 1 sends line n to the host
  input  wire logic [eir_pkg::EIR_ROUTABLE_LINES-1:0]  route_to_host,
  // Core side
  output logic                                   core_nmi,
  output logic [eir_pkg::EIR_CORE_LINES-1:0]     core_irq,
  output logic [eir_pkg::EIR_CODE_W-1:0]         core_event_code,
  // Host open-drain lines: out is always 0, oe high pulls low
  output logic                                   host_irq_a_n_o,
  output logic                                   host_irq_a_n_oe,
  output logic                                   host_irq_b_n_o,
  output logic                                   host_irq_b_n_oe,
  output logic                                   host_irq_c_n_o,
  output logic                                   host_irq_c_n_oe,
  output logic                                   host_irq_d_n_o,
  output logic                                   host_irq_d_n_oe
);
  import eir_pkg::*;

  localparam int NIN = 1 + EIR_CORE_LINES;
  localparam int HOST_LINES = 4;

  // Only four host lines exist, so the routable group cannot grow; the event
  // code must also be wide enough for the base code plus the highest line
  if (EIR_ROUTABLE_LINES != HOST_LINES) begin : g_routable_check
    $error("eir_router: routable line count must match the host lines");
  end
  if ((1 << EIR_CODE_W) < (EIR_CODE_XBASE + EIR_CORE_LINES)) begin : g_code_check
    $error("eir_router: event code too narrow for the line count");
  end

  eir_sync_if #(.W(NIN)) lvl ();

  // Every request enters through the synchroniser before any use
  assign lvl.raw_n = {ext_irq_core_only_n, ext_irq_routable_n, nmi_req_n};

  eir_sync #(.W(NIN)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .lvl      (lvl)
  );

  logic                         nmi_lvl;
  logic [EIR_CORE_LINES-1:0]    ext_lvl;
  assign nmi_lvl = ~lvl.clean_n[0];
  assign ext_lvl = ~lvl.clean_n[NIN-1:1];

  logic [EIR_ROUTABLE_LINES-1:0] route_q, route_d;
  logic                          core_nmi_q, core_nmi_d;
  logic [EIR_CORE_LINES-1:0]     core_irq_q, core_irq_d;
  logic [EIR_CODE_W-1:0]         code_q, code_d;
  logic [EIR_ROUTABLE_LINES-1:0] host_q, host_d;

  // Next values: route split, dedicated levels and priority code
  always_comb begin
    route_d    = route_to_host;
    core_nmi_d = nmi_lvl;
    core_irq_d = ext_lvl;
    host_d     = EIR_NONE4;
    for (int i = 0; i < EIR_ROUTABLE_LINES; i++) begin
      if (route_q[i] == EIR_TO_HOST) begin
        core_irq_d[i] = 1'b0;
        host_d[i]     = ext_lvl[i];
      end
    end
    // Lowest priority first; the loop runs high to low so the lowest index wins, then NMI overrides
    code_d = EIR_CODE_IDLE;
    for (int i = EIR_CORE_LINES - 1; i >= 0; i--) begin
      if (core_irq_d[i]) begin
        code_d = EIR_CODE_XBASE + EIR_CODE_W'(i);
      end
    end
    if (nmi_lvl) begin
      code_d = EIR_CODE_NMI;
    end
  end

  // Registered outputs; a host line simply follows its source level, so it
  // holds until the driver quiets the source
  always_ff @(posedge core_clk) begin
    if (rst) begin
      route_q    <= EIR_ROUTE_RST;
      core_nmi_q <= 1'b0;
      core_irq_q <= '0;
      code_q     <= EIR_CODE_IDLE;
      host_q     <= EIR_NONE4;
    end else begin
      route_q    <= route_d;
      core_nmi_q <= core_nmi_d;
      core_irq_q <= core_irq_d;
      code_q     <= code_d;
      host_q     <= host_d;
    end
  end

  assign core_nmi        = core_nmi_q;
  assign core_irq        = core_irq_q;
  assign core_event_code = code_q;

  // Open drain: never drive high, only enable a low; the level carries no
  // relation to any bus clock
  assign host_irq_a_n_o  = 1'b0;
  assign host_irq_b_n_o  = 1'b0;
  assign host_irq_c_n_o  = 1'b0;
  assign host_irq_d_n_o  = 1'b0;
  assign host_irq_a_n_oe = host_q[0];
  assign host_irq_b_n_oe = host_q[1];
  assign host_irq_c_n_oe = host_q[2];
  assign host_irq_d_n_oe = host_q[3];

  // Checks
  // The request must stand long enough to cross both flops
  sequence nmi_held_s;
    !nmi_req_n [*3];
  endsequence

  nmi_level_a: assert property (@(posedge core_clk) disable iff (rst)
    nmi_held_s |=> core_nmi && core_event_code == EIR_CODE_NMI)
    else $error("nmi not reported with top priority");

  nmi_priority_a: assert property (@(posedge core_clk) disable iff (rst)
    core_nmi |-> core_event_code == EIR_CODE_NMI)
    else $error("nmi event lost priority");

  dedicated_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(ext_lvl[7]) |-> core_irq[7])
    else $error("core-only line not on its own input");

  route_host_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(route_q[0] && ext_lvl[0]) |-> host_irq_a_n_oe && !core_irq[0])
    else $error("line 0 not sent to host line a");

  route_core_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(!route_q[2] && ext_lvl[2]) |-> !host_irq_c_n_oe && core_irq[2])
    else $error("line 2 not kept on core");

  float_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    !$past(ext_lvl[1]) |-> !host_irq_b_n_oe)
    else $error("host line b driven without a source");

  od_low_a: assert property (@(posedge core_clk) disable iff (rst)
    !host_irq_a_n_o && !host_irq_d_n_o)
    else $error("open-drain line driven high");

  hold_until_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    host_irq_d_n_oe && route_q[3] && ext_lvl[3] |=> host_irq_d_n_oe)
    else $error("host line d released while still pending");

  sync_delay_a: assert property (@(posedge core_clk) disable iff (rst)
    !ext_irq_core_only_n[0] [*3] |=> core_irq[4])
    else $error("synchronised request not seen in time");

  // Routing steps: a route setting and a request level both held long
  // enough to cross their flops before the outputs may be judged
  sequence route_b_held_s;
    (route_to_host[1] && !ext_irq_routable_n[1]) [*3];
  endsequence

  sequence route_c_core_held_s;
    (!route_to_host[2] && !ext_irq_routable_n[2]) [*3];
  endsequence

  sequence line5_held_s;
    !ext_irq_core_only_n[1] [*3];
  endsequence

  host_b_route_a: assert property (@(posedge core_clk) disable iff (rst)
    route_b_held_s |=> host_irq_b_n_oe && !core_irq[1])
    else $error("line 1 not sent to host line b");

  core_c_route_a: assert property (@(posedge core_clk) disable iff (rst)
    route_c_core_held_s |=> core_irq[2] && !host_irq_c_n_oe)
    else $error("line 2 leaked to host line c");

  dedicated_five_a: assert property (@(posedge core_clk) disable iff (rst)
    line5_held_s |=> core_irq[5])
    else $error("line 5 not on its own core input");

  code_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(!nmi_lvl && ext_lvl == '0) |-> core_event_code == EIR_CODE_IDLE)
    else $error("event code not idle without sources");

  code_line0_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(!nmi_lvl && !route_q[0] && ext_lvl[0]) |-> core_event_code == EIR_CODE_XBASE)
    else $error("line 0 did not win the event code");

  host_d_route_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(route_q[3] && ext_lvl[3]) |-> host_irq_d_n_oe && !core_irq[3])
    else $error("line 3 not sent to host line d");

  host_release_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(!ext_lvl[3]) |-> !host_irq_d_n_oe)
    else $error("host line d held without a source");

  od_pins_a: assert property (@(posedge core_clk) disable iff (rst)
    !host_irq_b_n_o && !host_irq_c_n_o)
    else $error("open-drain line b or c driven high");

  nmi_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(!nmi_lvl) |-> !core_nmi)
    else $error("nmi reported without a request");
endmodule
`default_nettype wire

/* hw/eir_sync.sv */
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser bank for active-low request levels
module eir_sync
  import eir_pkg::*;
#(
  parameter int W = 9
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Level path
  eir_sync_if.sync  lvl
);
  logic [W-1:0] meta_q, meta_d;
  logic [W-1:0] clean_q, clean_d;

  // Refuse an empty bank at elaboration
  if (W < 1) begin : g_w_check
    $error("eir_sync: W must be at least 1");
  end

  // Next values; first stage feeds only the second
  always_comb begin
    meta_d  = lvl.raw_n;
    clean_d = meta_q;
  end

  // Reset to the idle (high) level so nothing fires out of reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q  <= {W{EIR_SYNC_RST_N}};
      clean_q <= {W{EIR_SYNC_RST_N}};
    end else begin
      meta_q  <= meta_d;
      clean_q <= clean_d;
    end
  end

  assign lvl.clean_n = clean_q;
endmodule
`default_nettype wire

/* shared/eir_pkg.sv */
`default_nettype none
package eir_pkg;
  // Line counts
  localparam int EIR_ROUTABLE_LINES = 4;
  localparam int EIR_CORE_ONLY_LINES = 4;
  localparam int EIR_CORE_LINES = EIR_ROUTABLE_LINES + EIR_CORE_ONLY_LINES;
  // Synchroniser depth in flops
  localparam int EIR_SYNC_STAGES = 2;
  // Reset values
  localparam logic       EIR_SYNC_RST_N = 1'h1;
  localparam logic [3:0] EIR_ROUTE_RST  = 4'h0;
  localparam logic [3:0] EIR_NONE4      = 4'h0;
  // Event code width: zero means idle, 1 is the non-maskable request,
  // 2 + n is external line n; lower code wins
  localparam int EIR_CODE_W = 4;
  localparam logic [3:0] EIR_CODE_IDLE = 4'h0;
  localparam logic [3:0] EIR_CODE_NMI  = 4'h1;
  localparam logic [3:0] EIR_CODE_XBASE = 4'h2;
  // Route select per line: value of a routing bit
  localparam logic EIR_TO_CORE = 1'h0;
  localparam logic EIR_TO_HOST = 1'h1;
endpackage
`default_nettype wire

/* shared/eir_sync_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Carries raw asynchronous request levels into the synchroniser and the
// clean levels back to the router
interface eir_sync_if #(parameter int W = 9);
  logic [W-1:0] raw_n;
  logic [W-1:0] clean_n;
  modport router (output raw_n, input clean_n);
  modport sync   (input raw_n, output clean_n);
endinterface
`default_nettype wire

/* verif/eir_board_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Board sources and the pulled-up host lines
module eir_board_model (
  // Requests from the bench, active high
  input  wire logic       want_nmi,
  input  wire logic [7:0] want_irq,
  // Request lines to the router
  output logic            nmi_req_n,
  output logic [3:0]      xr_n,
  output logic [3:0]      xc_n,
  // Open-drain host lines
  input  wire logic [3:0] host_o,
  input  wire logic [3:0] host_oe,
  output logic [3:0]      host_n
);
  // A source asks for service by pulling its line low
  assign nmi_req_n = ~want_nmi;
  assign xr_n = ~want_irq[3:0];
  assign xc_n = ~want_irq[7:4];
  // Pull-up wins when nobody drives, so a stale low never lingers
  assign host_n = (host_oe & host_o) | ~host_oe;
endmodule
`default_nettype wire

/* verif/external_interrupt_router_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module external_interrupt_router_bench;
  import eir_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       want_nmi = 1'b0;
  logic [7:0] want_irq = 8'h00;
  logic [3:0] route = 4'h0;
  logic       nmi_n;
  logic [3:0] xr_n, xc_n, host_n, code;
  wire  [3:0] ho, hoe;
  logic       core_nmi;
  logic [7:0] core_irq;
  int         n_fail = 0;
  int         checks_done = 0;
  int         cyc = 0;
  eir_board_model brd_u (.want_nmi(want_nmi), .want_irq(want_irq), .nmi_req_n(nmi_n),
    .xr_n(xr_n), .xc_n(xc_n), .host_o(ho), .host_oe(hoe), .host_n(host_n));
  eir_router dut_u (.core_clk(core_clk), .rst(rst), .nmi_req_n(nmi_n),
    .ext_irq_routable_n(xr_n), .ext_irq_core_only_n(xc_n), .route_to_host(route),
    .core_nmi(core_nmi), .core_irq(core_irq), .core_event_code(code),
    .host_irq_a_n_o(ho[0]), .host_irq_a_n_oe(hoe[0]), .host_irq_b_n_o(ho[1]),
    .host_irq_b_n_oe(hoe[1]), .host_irq_c_n_o(ho[2]), .host_irq_c_n_oe(hoe[2]),
    .host_irq_d_n_o(ho[3]), .host_irq_d_n_oe(hoe[3]));
  // Free-running clock
  always #5 core_clk = ~core_clk;
  // Hang guard: tests need about 120 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 1000) begin
      n_fail++;
      results();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Lets n edges pass, then samples settled outputs
  task automatic wait_out(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic t_core();
    for (int n = 0; n < 8; n++) begin
      @(posedge core_clk);
      want_irq <= 8'h01 << n;
      wait_out(3);
      chk(core_irq, 8'h01 << n, "core line");
      chk({hoe, code}, 8'(EIR_CODE_XBASE + n), "code");
      @(posedge core_clk);
      want_irq <= 8'h00;
      wait_out(3);
      chk(core_irq, 8'h00, "core idle");
    end
    $display("done: core routing");
  endtask
  task automatic t_host();
    @(posedge core_clk);
    route <= 4'hF;
    want_irq <= 8'h0F;
    wait_out(2);
    chk({4'h0, host_n}, 8'h0F, "host early");
    wait_out(1);
    chk({4'h0, host_n}, 8'h00, "host low");
    chk(core_irq, 8'h00, "core masked");
    wait_out(8);
    chk({4'h0, host_n}, 8'h00, "host held");
    // Driver clears each source in turn
    for (int n = 0; n < 4; n++) begin
      @(posedge core_clk);
      want_irq <= want_irq & ~(8'h01 << n);
      wait_out(3);
      chk({4'h0, host_n}, 8'((16'h1 << (n + 1)) - 1), "host clear");
    end
    @(posedge core_clk);
    route <= 4'h5;
    want_irq <= 8'h0F;
    wait_out(3);
    chk({host_n, core_irq[3:0]}, 8'hAA, "mixed route");
    @(posedge core_clk);
    want_irq <= 8'h00;
    route <= 4'h0;
    wait_out(3);
    $display("done: host routing");
  endtask
  task automatic t_nmi();
    @(posedge core_clk);
    want_nmi <= 1'b1;
    want_irq <= 8'hFF;
    wait_out(3);
    chk({3'h0, core_nmi, code}, 8'h11, "nmi wins");
    chk(core_irq, 8'hFF, "all lines");
    @(posedge core_clk);
    want_nmi <= 1'b0;
    wait_out(3);
    chk({3'h0, core_nmi, code}, 8'(EIR_CODE_XBASE), "nmi gone");
    @(posedge core_clk);
    want_irq <= 8'h00;
    wait_out(3);
    $display("done: nmi priority");
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    wait_out(1);
    chk({hoe, code}, 8'h00, "reset oe");
    chk(core_irq | {7'h0, core_nmi}, 8'h00, "reset core");
    $display("done: reset");
    t_core();
    t_host();
    t_nmi();
    results();
  end
endmodule
`default_nettype wire
